// ---- hdl/ecpp_defs.svh ----
`ifndef ECPP_DEFS_SVH
`define ECPP_DEFS_SVH

// Register offsets from the port base address.
`define ECPP_OFF_DATA 16'h0000
`define ECPP_OFF_DSR 16'h0001
`define ECPP_OFF_DCR 16'h0002
`define ECPP_OFF_FIFO 16'h0400
`define ECPP_OFF_CFGB 16'h0401
`define ECPP_OFF_ECR 16'h0402

// Extended control field positions.
`define ECPP_ECR_MODE_HI 7
`define ECPP_ECR_MODE_LO 5
`define ECPP_ECR_NERR 4
`define ECPP_ECR_DMAEN 3
`define ECPP_ECR_SVC 2
`define ECPP_ECR_FULL 1
`define ECPP_ECR_EMPTY 0

// Device control field positions.
`define ECPP_DCR_STROBE 0
`define ECPP_DCR_AUTOFD 1
`define ECPP_DCR_INIT 2
`define ECPP_DCR_SELIN 3
`define ECPP_DCR_DIR 5

// Reset values and fixed read values.
`define ECPP_ECR_RST 8'h15
`define ECPP_CFGA_VAL 8'h10
`define ECPP_IRQ_SEL 3'h0
`define ECPP_DMA_SEL 3'h0

// FIFO geometry and service thresholds.
`define ECPP_FIFO_DEPTH 16
`define ECPP_WR_THR 5'h08
`define ECPP_RD_THR 5'h08

`endif

// ---- hdl/ecpp_pkg.sv ----
package ecpp_pkg;

    // Operating modes held in the extended control register.
    typedef enum logic [2:0] {
        ECPP_M_STD,
        ECPP_M_BYTE,
        ECPP_M_COMPAT_FIFO_PORT,
        ECPP_M_ECP,
        ECPP_M_EPP,
        ECPP_M_RSVD,
        ECPP_M_TEST,
        ECPP_M_CFG
    } ecpp_mode_t;

    // Link handshake states.
    typedef enum logic [2:0] {
        ECPP_L_IDLE,
        ECPP_L_FWD_WAIT,
        ECPP_L_FWD_STB,
        ECPP_L_FWD_REL,
        ECPP_L_REV_REQ,
        ECPP_L_REV_ACK,
        ECPP_L_REV_RPT
    } ecpp_link_t;

    typedef logic [7:0] ecpp_byte_t;

endpackage : ecpp_pkg

// ---- hdl/ecpp_port.sv ----
`include "ecpp_defs.svh"
// Function
// - One 16-byte FIFO serves both forward and reverse transfers.
// - Compatibility FIFO mode runs the strobe and busy handshake in hardware.
// - Reverse RLE byte is not stored; next data byte is stored run length plus one times.
// - Forward compression is omitted; only reverse decompression is built.
// - DMA moves ECP data both directions; no negotiation is done.
// - Forward strobe asserts to latch data, interlocked with peripheral ack.
// - In ECP mode, data bus driven only while reverse-ack permits it.
// - Forward host ack level shows address versus data byte.
// - Reverse host ack requests bytes, interlocked with the peripheral clock.
// - Asserted request or fault line raises the error interrupt condition in ECP mode.
// - Reverse request line is only a hint; direction stays under host control.
// - Direction line low selects reverse, high selects forward.
// - Select-in output stays deasserted throughout ECP mode.
// - Offset zero decodes data or address FIFO by mode; status/control always.
// - Offset 400h decodes FIFO or config A by mode; 401h only in configuration mode; 402h fixed.
// - Offsets add to a base address; every decode needs address enable low.
// - Three-bit mode encodes standard through configuration as listed.
// - Mode field is bits 7 to 5 of extended control, read and write.
// - Every port word through FIFO and link is eight bits.
module ecpp_port (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] base_addr_i,
    input wire logic [15:0] io_addr_i,
    input wire logic aen_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire ecpp_pkg::ecpp_byte_t io_wdata_i,
    output ecpp_pkg::ecpp_byte_t io_rdata_o,
    output logic dma_req_o,
    input wire logic dma_ack_i,
    input wire logic dma_tc_i,
    output logic error_irq_o,
    output logic host_clock_strobe_n_o,
    output logic host_ack_pin_o,
    output logic direction_line_o,
    output logic select_in_line_o,
    input wire ecpp_pkg::ecpp_byte_t port_data_bus_i,
    output ecpp_pkg::ecpp_byte_t port_data_bus_o,
    output logic port_data_bus_oe_o,
    input wire logic peripheral_clock_line_i,
    input wire logic peripheral_acknowledge_i,
    input wire logic reverse_ack_pin_i,
    input wire logic request_fault_pin_i,
    input wire logic select_i
);
    import ecpp_pkg::*;

    ecpp_byte_t data_q;
    logic [5:0] dcr_q;
    ecpp_mode_t mode_q;
    logic nerr_en_q;
    logic dma_en_q;
    logic svc_q;
    logic [8:0] fifo_mem [`ECPP_FIFO_DEPTH];
    logic [3:0] wr_ptr_q;
    logic [3:0] rd_ptr_q;
    logic [4:0] count_q;
    ecpp_byte_t last_rd_q;
    ecpp_link_t link_q;
    ecpp_byte_t tx_q;
    logic tx_tag_q;
    logic strobe_q;
    logic hack_q;
    logic rle_pend_q;
    logic [6:0] rle_cnt_q;
    logic [7:0] rep_left_q;
    ecpp_byte_t rep_byte_q;
    logic fault_q;

    logic [15:0] off;
    logic sel_data, sel_dsr, sel_dcr, sel_fifo, sel_cfgb, sel_ecr;
    logic is_ecp, dir_rev, full, empty;
    logic bus_wr_fifo, bus_rd_fifo, lk_push, lk_pop, push, pop;
    logic [8:0] push_word;
    logic [8:0] head;
    logic cap_cmd, cap_rle, cap_plain;
    ecpp_byte_t rd_mux;

    // Offsets are taken relative to the base; AEN high marks a DMA cycle.
    assign off = 16'(io_addr_i - base_addr_i);
    assign sel_data = !aen_i && off == `ECPP_OFF_DATA;
    assign sel_dsr = !aen_i && off == `ECPP_OFF_DSR;
    assign sel_dcr = !aen_i && off == `ECPP_OFF_DCR;
    assign sel_fifo = !aen_i && off == `ECPP_OFF_FIFO;
    assign sel_cfgb = !aen_i && off == `ECPP_OFF_CFGB && mode_q == ECPP_M_CFG;
    assign sel_ecr = !aen_i && off == `ECPP_OFF_ECR;

    assign is_ecp = mode_q == ECPP_M_ECP;
    assign dir_rev = dcr_q[`ECPP_DCR_DIR];
    assign full = count_q == 5'(`ECPP_FIFO_DEPTH);
    assign empty = count_q == 5'h00;
    assign head = fifo_mem[rd_ptr_q];

    // Bus or DMA writes fill the FIFO in the modes that own it; an ECP
    // write at offset zero is tagged as address or RLE.
    always_comb begin
        bus_wr_fifo = 1'b0;
        bus_rd_fifo = 1'b0;
        if (io_wr_i && (dma_ack_i || sel_fifo)) begin
            bus_wr_fifo = mode_q == ECPP_M_COMPAT_FIFO_PORT || mode_q == ECPP_M_TEST ||
                (is_ecp && !dir_rev);
        end
        if (io_wr_i && sel_data && is_ecp && !dir_rev) begin
            bus_wr_fifo = 1'b1;
        end
        if (io_rd_i && (dma_ack_i || sel_fifo)) begin
            bus_rd_fifo = mode_q == ECPP_M_TEST || (is_ecp && dir_rev);
        end
    end

    // Reverse capture: a command byte with bit 7 low is a run length.
    assign cap_cmd = !peripheral_acknowledge_i;
    assign cap_rle = cap_cmd && !port_data_bus_i[7];
    assign cap_plain = !cap_rle && !(rle_pend_q && !cap_cmd);
    assign lk_push = (link_q == ECPP_L_REV_REQ && !peripheral_clock_line_i &&
        cap_plain) || (link_q == ECPP_L_REV_RPT);
    // Forward drain runs only in compatibility FIFO and forward ECP modes.
    assign lk_pop = link_q == ECPP_L_IDLE && !empty &&
        (mode_q == ECPP_M_COMPAT_FIFO_PORT || (is_ecp && !dir_rev));
    assign push = (bus_wr_fifo || lk_push) && !full;
    assign pop = (bus_rd_fifo || lk_pop) && !empty;

    // Word layout: tag in bit 8, port word below it.
    always_comb begin
        push_word = {1'b0, io_wdata_i};
        if (lk_push) begin
            if (link_q == ECPP_L_REV_RPT) begin
                push_word = {1'b0, rep_byte_q};
            end else begin
                push_word = {cap_cmd, port_data_bus_i};
            end
        end else if (sel_data && !dma_ack_i) begin
            push_word = {1'b1, io_wdata_i};
        end
    end

    // FIFO storage. Writes to a full FIFO are dropped; the full bit lets
    // software and DMA avoid that.
    always_ff @(posedge mclk_i) begin
        if (push) begin
            fifo_mem[wr_ptr_q] <= push_word;
        end
    end

    // FIFO pointers and fill count.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_q <= 4'h0;
            rd_ptr_q <= 4'h0;
            count_q <= 5'h00;
        end else if (io_wr_i && sel_ecr && io_wdata_i[7:6] == 2'b00) begin
            // Dropping to standard or byte mode abandons any queued bytes.
            wr_ptr_q <= 4'h0;
            rd_ptr_q <= 4'h0;
            count_q <= 5'h00;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 4'h1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 4'h1;
            end
            if (push && !pop) begin
                count_q <= count_q + 5'h01;
            end else if (pop && !push) begin
                count_q <= count_q - 5'h01;
            end
        end
    end

    // Remember the last byte read so an empty test FIFO re-reads it.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_rd_q <= 8'h00;
        end else if (bus_rd_fifo && !empty) begin
            last_rd_q <= head[7:0];
        end
    end

    // Data register and device control register.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_q <= 8'h00;
            dcr_q <= 6'h00;
        end else begin
            if (io_wr_i && sel_data && mode_q[2:1] == 2'b00) begin
                data_q <= io_wdata_i;
            end
            if (io_wr_i && sel_dcr) begin
                dcr_q <= io_wdata_i[5:0];
            end
        end
    end

    // Extended control. Hardware sets the service bit only while it is clear: it
    // overrides a same-cycle write of zero then, but a same-cycle clear of a set bit wins.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= ecpp_mode_t'(3'(`ECPP_ECR_RST >> `ECPP_ECR_MODE_LO));
            nerr_en_q <= 1'(`ECPP_ECR_RST >> `ECPP_ECR_NERR);
            dma_en_q <= 1'(`ECPP_ECR_RST >> `ECPP_ECR_DMAEN);
            svc_q <= 1'(`ECPP_ECR_RST >> `ECPP_ECR_SVC);
        end else begin
            if (io_wr_i && sel_ecr) begin
                mode_q <= ecpp_mode_t'(io_wdata_i[`ECPP_ECR_MODE_HI:
                    `ECPP_ECR_MODE_LO]);
                nerr_en_q <= io_wdata_i[`ECPP_ECR_NERR];
                dma_en_q <= io_wdata_i[`ECPP_ECR_DMAEN];
                svc_q <= io_wdata_i[`ECPP_ECR_SVC];
            end
            if (!svc_q && ((dma_en_q && dma_tc_i) || (!dma_en_q && (dir_rev ?
                count_q >= `ECPP_RD_THR :
                5'(`ECPP_FIFO_DEPTH) - count_q >= `ECPP_WR_THR)))) begin
                svc_q <= 1'b1;
            end
        end
    end

    // Read multiplexer; unmapped offsets and reserved bits read zero.
    always_comb begin
        rd_mux = 8'h00;
        if (dma_ack_i || sel_fifo) begin
            if (mode_q == ECPP_M_CFG && !dma_ack_i) begin
                rd_mux = `ECPP_CFGA_VAL;
            end else begin
                rd_mux = empty ? last_rd_q : head[7:0];
            end
        end else if (sel_data) begin
            rd_mux = mode_q == ECPP_M_BYTE && dir_rev ? port_data_bus_i : data_q;
        end else if (sel_dsr) begin
            rd_mux = {!peripheral_acknowledge_i, peripheral_clock_line_i,
                reverse_ack_pin_i, select_i, request_fault_pin_i, 3'b000};
        end else if (sel_dcr) begin
            rd_mux = {2'b00, dcr_q};
        end else if (sel_cfgb) begin
            rd_mux = {1'b0, fault_q, `ECPP_IRQ_SEL, `ECPP_DMA_SEL};
        end else if (sel_ecr) begin
            rd_mux = {mode_q, nerr_en_q, dma_en_q, svc_q, full, empty};
        end
    end

    // Read data is registered and valid the cycle after the read strobe.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            io_rdata_o <= 8'h00;
        end else if (io_rd_i) begin
            io_rdata_o <= rd_mux;
        end
    end

    // DMA asks for service while the FIFO has room (forward) or bytes
    // (reverse); it holds off while the service bit is set.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dma_req_o <= 1'b0;
        end else begin
            dma_req_o <= dma_en_q && !svc_q && !dma_tc_i &&
                (mode_q == ECPP_M_COMPAT_FIFO_PORT || is_ecp || mode_q == ECPP_M_TEST) &&
                (dir_rev && mode_q != ECPP_M_COMPAT_FIFO_PORT ? count_q > 5'h01 || (
                count_q == 5'h01 && !pop) : count_q < 5'h0f);
        end
    end

    // Error condition: fault line low in ECP mode with the interrupt
    // enabled. The request is only reported; direction stays ours.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_q <= 1'b0;
            error_irq_o <= 1'b0;
        end else begin
            fault_q <= !request_fault_pin_i;
            error_irq_o <= is_ecp && !nerr_en_q && !request_fault_pin_i;
        end
    end

    // Link handshake engine. Forward words leave the FIFO head; reverse
    // words are gathered only when the peripheral has granted reverse.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_q <= ECPP_L_IDLE;
            tx_q <= 8'h00;
            tx_tag_q <= 1'b0;
            strobe_q <= 1'b0;
            hack_q <= 1'b0;
            rle_pend_q <= 1'b0;
            rle_cnt_q <= 7'h00;
            rep_left_q <= 8'h00;
            rep_byte_q <= 8'h00;
        end else begin
            unique case (link_q)
                ECPP_L_IDLE: begin
                    strobe_q <= 1'b0;
                    hack_q <= 1'b0;
                    if (lk_pop) begin
                        tx_q <= head[7:0];
                        tx_tag_q <= head[8] && is_ecp;
                        link_q <= ECPP_L_FWD_WAIT;
                    end else if (is_ecp && dir_rev && !reverse_ack_pin_i &&
                        !full) begin
                        link_q <= ECPP_L_REV_REQ;
                    end
                end
                ECPP_L_FWD_WAIT: begin
                    if (!peripheral_acknowledge_i) begin
                        strobe_q <= 1'b1;
                        link_q <= ECPP_L_FWD_STB;
                    end
                end
                ECPP_L_FWD_STB: begin
                    if (peripheral_acknowledge_i) begin
                        strobe_q <= 1'b0;
                        link_q <= ECPP_L_FWD_REL;
                    end
                end
                ECPP_L_FWD_REL: begin
                    link_q <= ECPP_L_IDLE;
                end
                ECPP_L_REV_REQ: begin
                    hack_q <= 1'b0;
                    if (!is_ecp || !dir_rev) begin
                        link_q <= ECPP_L_IDLE;
                    end else if (!peripheral_clock_line_i) begin
                        hack_q <= 1'b1;
                        link_q <= ECPP_L_REV_ACK;
                        if (cap_rle) begin
                            rle_cnt_q <= port_data_bus_i[6:0];
                            rle_pend_q <= 1'b1;
                        end else if (rle_pend_q && !cap_cmd) begin
                            rep_byte_q <= port_data_bus_i;
                            rep_left_q <= {1'b0, rle_cnt_q} + 8'h01;
                            rle_pend_q <= 1'b0;
                        end
                    end
                end
                ECPP_L_REV_ACK: begin
                    if (peripheral_clock_line_i) begin
                        link_q <= rep_left_q != 8'h00 ? ECPP_L_REV_RPT :
                            ECPP_L_IDLE;
                    end
                end
                ECPP_L_REV_RPT: begin
                    if (!full) begin
                        rep_left_q <= rep_left_q - 8'h01;
                        if (rep_left_q == 8'h01) begin
                            link_q <= ECPP_L_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Pin drivers, registered. ECP and compatibility FIFO modes hand the
    // strobe to the engine, ECP mode also the host ack; other modes follow control bits.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            host_clock_strobe_n_o <= 1'b1;
            host_ack_pin_o <= 1'b1;
            direction_line_o <= 1'b0;
            select_in_line_o <= 1'b1;
            port_data_bus_o <= 8'h00;
            port_data_bus_oe_o <= 1'b0;
        end else begin
            if (is_ecp || mode_q == ECPP_M_COMPAT_FIFO_PORT) begin
                host_clock_strobe_n_o <= !strobe_q;
            end else begin
                host_clock_strobe_n_o <= !dcr_q[`ECPP_DCR_STROBE];
            end
            if (is_ecp) begin
                host_ack_pin_o <= dir_rev ? hack_q : !tx_tag_q;
                direction_line_o <= !dir_rev;
                select_in_line_o <= 1'b1;
                port_data_bus_oe_o <= !dir_rev && reverse_ack_pin_i;
            end else begin
                host_ack_pin_o <= !dcr_q[`ECPP_DCR_AUTOFD];
                direction_line_o <= dcr_q[`ECPP_DCR_INIT];
                select_in_line_o <= !dcr_q[`ECPP_DCR_SELIN];
                port_data_bus_oe_o <= !(mode_q != ECPP_M_STD &&
                    mode_q != ECPP_M_COMPAT_FIFO_PORT && dir_rev);
            end
            port_data_bus_o <= mode_q[2:1] == 2'b00 ? data_q : tx_q;
        end
    end

endmodule : ecpp_port

// ---- dv/ecpp_port_checker.sv ----
module ecpp_port_checker (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] base_addr_i,
    input wire logic [15:0] io_addr_i,
    input wire logic aen_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire ecpp_pkg::ecpp_byte_t io_wdata_i,
    input wire ecpp_pkg::ecpp_byte_t io_rdata_o,
    input wire logic dma_req_o,
    input wire logic dma_ack_i,
    input wire logic dma_tc_i,
    input wire logic error_irq_o,
    input wire logic host_clock_strobe_n_o,
    input wire logic host_ack_pin_o,
    input wire logic direction_line_o,
    input wire logic select_in_line_o,
    input wire logic port_data_bus_oe_o,
    input wire logic peripheral_clock_line_i,
    input wire logic peripheral_acknowledge_i,
    input wire logic reverse_ack_pin_i,
    input wire logic request_fault_pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import ecpp_pkg::*;

    // Shadow copies of mode, error enable and direction, kept from the bus
    // writes so that pin behaviour can be judged from the ports alone.
    logic [2:0] mode_q;
    logic nerr_q;
    logic dir_q;
    wire logic [15:0] off = io_addr_i - base_addr_i;
    wire logic wr_ok = io_wr_i && !aen_i && !dma_ack_i;
    wire logic rd_ok = io_rd_i && !aen_i && !dma_ack_i;

    // Extended control shadow.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= 3'h0;
            nerr_q <= 1'b1;
        end else if (wr_ok && off == 16'h0402) begin
            mode_q <= io_wdata_i[7:5];
            nerr_q <= io_wdata_i[4];
        end
    end

    // Device control direction shadow.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_q <= 1'b0;
        end else if (wr_ok && off == 16'h0002) begin
            dir_q <= io_wdata_i[5];
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_selin_ecp_high: assert property (
        $past(mode_q) == 3'h3 |-> select_in_line_o)
        else $error("select-in asserted in ECP mode");
    a_dir_follows_ctl: assert property (
        $past(mode_q) == 3'h3 |-> direction_line_o == !$past(dir_q))
        else $error("direction line disagrees with control");
    a_bus_off_rev: assert property (
        $past(mode_q == 3'h3 && !reverse_ack_pin_i) |-> !port_data_bus_oe_o)
        else $error("data bus driven while reverse granted");
    a_error_irq_level: assert property (
        error_irq_o == $past(mode_q == 3'h3 && !nerr_q && !request_fault_pin_i))
        else $error("error interrupt level wrong");
    a_strobe_holds: assert property (
        mode_q[2:1] == 2'b01 && $past(mode_q[2:1]) == 2'b01
        && !host_clock_strobe_n_o && !peripheral_acknowledge_i
        |=> !host_clock_strobe_n_o)
        else $error("strobe released before peripheral busy");
    a_host_acknowledge_answers: assert property (
        mode_q == 3'h3 && dir_q && !host_ack_pin_o && !peripheral_clock_line_i
        |-> ##[1:3] host_ack_pin_o)
        else $error("host ack did not answer peripheral clock");
    a_mode_readback: assert property (
        rd_ok && off == 16'h0402 |=> io_rdata_o[7:5] == $past(mode_q))
        else $error("mode field read back wrong");
    a_tc_stops_dma: assert property (
        dma_tc_i && dma_ack_i |-> ##2 !dma_req_o)
        else $error("dma request after terminal count");
endmodule : ecpp_port_checker

bind ecpp_port ecpp_port_checker i_chk (
    .mclk_i, .rst_n_i, .base_addr_i, .io_addr_i, .aen_i, .io_rd_i, .io_wr_i,
    .io_wdata_i, .io_rdata_o, .dma_req_o, .dma_ack_i, .dma_tc_i,
    .error_irq_o, .host_clock_strobe_n_o, .host_ack_pin_o,
    .direction_line_o, .select_in_line_o, .port_data_bus_oe_o,
    .peripheral_clock_line_i, .peripheral_acknowledge_i,
    .reverse_ack_pin_i, .request_fault_pin_i
);

// ---- dv/ecpp_periph_model.sv ----
module ecpp_periph_model (
    input wire logic mclk_i,
    input wire logic strobe_n_i,
    input wire logic host_ack_i,
    input wire logic direction_i,
    input wire logic select_in_i,
    input wire logic [7:0] data_i,
    output logic busy_o,
    output logic clk_n_o,
    output logic rev_ack_o,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Received bytes with the host ack level in the top bit.
    logic [8:0] rx_q[$];
    int lag = 0;

    initial begin
        busy_o = 1'b0;
        clk_n_o = 1'b1;
        rev_ack_o = 1'b1;
        data_o = 8'h00;
    end

    // The grant follows the direction line a cycle later.
    always @(posedge mclk_i) begin
        rev_ack_o <= direction_i;
    end

    // Forward: latch on the falling strobe, stay busy until it is released.
    // The lag makes the peripheral slow so the host must really wait.
    always @(negedge strobe_n_i) begin
        rx_q.push_back({host_ack_i, data_i});
        repeat (lag) @(posedge mclk_i);
        busy_o <= 1'b1;
        @(posedge strobe_n_i);
        @(posedge mclk_i);
        busy_o <= 1'b0;
    end

    // Reverse: one byte per host request; busy low marks a command.
    task automatic send(input logic [7:0] b, input logic cmd);
        wait (!host_ack_i && select_in_i);
        @(posedge mclk_i);
        data_o <= b;
        busy_o <= !cmd;
        @(posedge mclk_i);
        clk_n_o <= 1'b0;
        wait (host_ack_i);
        @(posedge mclk_i);
        clk_n_o <= 1'b1;
        data_o <= ~b;
    endtask : send
endmodule : ecpp_periph_model

// ---- dv/test_ecp_parallel_port.sv ----
module test_ecp_parallel_port;
    timeunit 1ns;
    timeprecision 1ps;
    import ecpp_pkg::*;

    localparam logic [15:0] BASE = 16'h0378;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] io_addr_i = 16'h0000;
    logic aen_i = 1'b0, io_rd_i = 1'b0, io_wr_i = 1'b0;
    logic dma_ack_i = 1'b0, dma_tc_i = 1'b0, fault_n = 1'b1;
    ecpp_byte_t io_wdata_i = 8'h00;
    ecpp_byte_t io_rdata_o, dut_d, per_d;
    logic dma_req_o, error_irq_o, stb_n, hack, dirl, selin, oe;
    wire logic busy, pclk_n, rack;
    wire ecpp_byte_t pd = oe ? dut_d : per_d;
    int mismatches = 0;
    int comparisons = 0;

    ecpp_port i_dut (
        .mclk_i, .rst_n_i, .base_addr_i(BASE), .io_addr_i, .aen_i, .io_rd_i,
        .io_wr_i, .io_wdata_i, .io_rdata_o, .dma_req_o, .dma_ack_i,
        .dma_tc_i, .error_irq_o, .host_clock_strobe_n_o(stb_n),
        .host_ack_pin_o(hack), .direction_line_o(dirl),
        .select_in_line_o(selin), .port_data_bus_i(pd),
        .port_data_bus_o(dut_d), .port_data_bus_oe_o(oe),
        .peripheral_clock_line_i(pclk_n), .peripheral_acknowledge_i(busy),
        .reverse_ack_pin_i(rack), .request_fault_pin_i(fault_n),
        .select_i(1'b1)
    );

    ecpp_periph_model i_per (
        .mclk_i, .strobe_n_i(stb_n), .host_ack_i(hack), .direction_i(dirl),
        .select_in_i(selin), .data_i(pd), .busy_o(busy), .clk_n_o(pclk_n),
        .rev_ack_o(rack), .data_o(per_d)
    );

    always #5 mclk_i = ~mclk_i;

    task automatic chk(input string what, input logic [8:0] exp,
                       input logic [8:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // Bus cycles: one strobe cycle, launched and released on falling edges.
    task automatic wr(input logic [15:0] off, input ecpp_byte_t d);
        @(negedge mclk_i);
        io_addr_i = BASE + off;
        io_wdata_i = d;
        io_wr_i = 1'b1;
        @(negedge mclk_i);
        io_wr_i = 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] off, input ecpp_byte_t e,
                      input ecpp_byte_t m);
        @(negedge mclk_i);
        io_addr_i = BASE + off;
        io_rd_i = 1'b1;
        @(negedge mclk_i);
        io_rd_i = 1'b0;
        chk("read data", {1'b0, e & m}, {1'b0, io_rdata_o & m});
    endtask : rd

    task automatic ticks(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : ticks

    task automatic wait_rx(input int n);
        for (int i = 0; i < 300 && i_per.rx_q.size() < n; i++)
            @(negedge mclk_i);
    endtask : wait_rx

    task automatic results();
        $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // The tests need a few hundred cycles; a hang is cut off well beyond.
    initial begin
        repeat (20000) @(posedge mclk_i);
        mismatches++;
        results();
    end

    initial begin
        repeat (10) @(posedge mclk_i);
        @(negedge mclk_i);
        rst_n_i = 1'b1;
        rd(16'h0402, 8'h15, 8'hff);
        rd(16'h0002, 8'h00, 8'hff);
        rd(16'h0400, 8'h00, 8'hff);
        rd(16'h0003, 8'h00, 8'hff);
        wr(16'h0000, 8'h3c);
        rd(16'h0000, 8'h3c, 8'hff);
        aen_i = 1'b1;
        wr(16'h0002, 8'h3f);
        aen_i = 1'b0;
        rd(16'h0002, 8'h00, 8'hff);
        for (int m = 0; m < 8; m++) begin
            wr(16'h0402, {m[2:0], 5'h15});
            rd(16'h0402, {m[2:0], 5'h00}, 8'he0);
        end
        rd(16'h0400, 8'h10, 8'hff);
        wr(16'h0400, 8'hff);
        rd(16'h0400, 8'h10, 8'hff);
        rd(16'h0401, 8'h00, 8'hff);
        // Test FIFO: overfill by one, drain, then underrun once.
        wr(16'h0402, 8'hd5);
        for (int i = 0; i < 17; i++)
            wr(16'h0400, i[7:0]);
        rd(16'h0402, 8'h02, 8'h03);
        for (int i = 0; i < 16; i++)
            rd(16'h0400, i[7:0], 8'hff);
        rd(16'h0400, 8'h0f, 8'hff);
        rd(16'h0402, 8'h01, 8'h03);
        // One DMA byte ending on terminal count.
        wr(16'h0402, 8'h15);
        wr(16'h0402, 8'hc8);
        for (int i = 0; i < 20 && dma_req_o !== 1'b1; i++)
            @(negedge mclk_i);
        chk("dma request", 9'h001, {8'h00, dma_req_o});
        @(negedge mclk_i);
        aen_i = 1'b1;
        dma_ack_i = 1'b1;
        io_wr_i = 1'b1;
        io_wdata_i = 8'h5a;
        dma_tc_i = 1'b1;
        @(negedge mclk_i);
        aen_i = 1'b0;
        dma_ack_i = 1'b0;
        io_wr_i = 1'b0;
        dma_tc_i = 1'b0;
        ticks(3);
        chk("dma request", 9'h000, {8'h00, dma_req_o});
        rd(16'h0402, 8'h04, 8'h04);
        rd(16'h0400, 8'h5a, 8'hff);
        // Compatibility FIFO against a slow peripheral.
        wr(16'h0402, 8'h15);
        wr(16'h0402, 8'h55);
        i_per.lag = 4;
        wr(16'h0400, 8'ha1);
        wr(16'h0400, 8'ha2);
        wait_rx(2);
        chk("link byte", 9'h1a1, i_per.rx_q.pop_front());
        chk("link byte", 9'h1a2, i_per.rx_q.pop_front());
        i_per.lag = 0;
        // ECP forward: address then data, ack level marks which.
        wr(16'h0402, 8'h75);
        wr(16'h0000, 8'h21);
        wr(16'h0400, 8'h5a);
        wait_rx(2);
        chk("link byte", 9'h021, i_per.rx_q.pop_front());
        chk("link byte", 9'h15a, i_per.rx_q.pop_front());
        // ECP reverse with a run length of two, so three copies.
        wr(16'h0002, 8'h20);
        ticks(2);
        chk("direction", 9'h000, {8'h00, dirl});
        i_per.send(8'h02, 1'b1);
        i_per.send(8'h77, 1'b0);
        i_per.send(8'h33, 1'b0);
        ticks(6);
        for (int i = 0; i < 3; i++)
            rd(16'h0400, 8'h77, 8'hff);
        rd(16'h0400, 8'h33, 8'hff);
        rd(16'h0402, 8'h01, 8'h01);
        // Fault line: error level, status bit, no change of direction.
        wr(16'h0402, 8'h65);
        fault_n = 1'b0;
        ticks(3);
        chk("error level", 9'h001, {8'h00, error_irq_o});
        chk("direction", 9'h000, {8'h00, dirl});
        rd(16'h0001, 8'h10, 8'h18);
        fault_n = 1'b1;
        ticks(3);
        chk("error level", 9'h000, {8'h00, error_irq_o});
        results();
    end
endmodule : test_ecp_parallel_port
